// *** src/ser_pkg.sv ***
// Purpose: shared constants and types for the status event reporting block
// Assumes: text commands are already parsed into one-cycle command strobes
// Notes: error codes are carried as signed 16-bit numbers
package ser_pkg;

	typedef enum logic [3:0]
	{
		SER_OP_NONE,
		SER_OP_CLEAR_STATUS,
		SER_OP_EVENT_MASK_WR,
		SER_OP_EVENT_MASK_RD,
		SER_OP_EVENT_RD,
		SER_OP_SUMMARY_RD,
		SER_OP_SERVICE_MASK_WR,
		SER_OP_SERVICE_MASK_RD,
		SER_OP_ERROR_RD
	} ser_op_t;

	// status summary byte layout
	localparam int SER_BIT_MSG_WAIT = 4;
	localparam int SER_BIT_EVT_SUM = 5;
	localparam int SER_BIT_MASTER = 6;
	localparam logic [7:0] SER_SERVICE_MASK_USED = 8'h30;

	// latched event register layout
	localparam int SER_BIT_QUERY_ERR = 2;
	localparam int SER_BIT_DEVICE_ERR = 3;
	localparam int SER_BIT_EXEC_ERR = 4;
	localparam int SER_BIT_CMD_ERR = 5;
	localparam int SER_BIT_POWER_ON = 7;

	// reset values
	localparam logic [7:0] SER_EVENT_RESET = 8'h80;
	localparam logic [7:0] SER_EVENT_MASK_RESET = 8'h00;
	localparam logic [7:0] SER_SERVICE_MASK_RESET = 8'h00;

	// error codes
	localparam logic signed [15:0] SER_ERR_NONE = 16'sh0000;
	localparam logic signed [15:0] SER_ERR_CMD = -16'sd100;
	localparam logic signed [15:0] SER_ERR_SYNTAX = -16'sd102;
	localparam logic signed [15:0] SER_ERR_PARAM = -16'sd108;
	localparam logic signed [15:0] SER_ERR_RANGE = -16'sd222;
	localparam logic signed [15:0] SER_ERR_OVERFLOW = -16'sd350;
	localparam logic signed [15:0] SER_ERR_QUERY = -16'sd400;
	localparam logic [15:0] SER_GROUP_SPAN = 16'd100;

	// error queue geometry
	localparam int SER_QUEUE_DEPTH = 8;
	localparam int SER_QUEUE_AW = 3;

endpackage

// *** src/ser_err_queue.sv ***
// Purpose: error number queue, oldest out first, registered read data
// Assumes: write and read strobes are single-cycle pulses
// Notes: a write into a full queue turns the newest slot into overflow
`timescale 1ns/1ps
module ser_err_queue
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic clear,
	input wire logic wr_en,
	input wire logic signed [15:0] wr_data,
	input wire logic rd_en,
	output logic signed [15:0] rd_data,
	output logic full,
	output logic empty
);

	logic signed [15:0] mem [ser_pkg::SER_QUEUE_DEPTH];
	logic [ser_pkg::SER_QUEUE_AW-1:0] wp;
	logic [ser_pkg::SER_QUEUE_AW-1:0] rp;
	logic [ser_pkg::SER_QUEUE_AW:0] count;
	logic do_rd;
	logic do_wr;

	assign do_rd = rd_en && count != '0;
	// a read frees a slot in the same cycle, so a write then still fits
	assign do_wr = wr_en && (count != ser_pkg::SER_QUEUE_DEPTH || do_rd);
	assign full = count == ser_pkg::SER_QUEUE_DEPTH;
	assign empty = count == '0;

	////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk)
	begin
		if (do_wr)
			mem[wp] <= wr_data;
		else if (wr_en)
			mem[wp - 1'b1] <= ser_pkg::SER_ERR_OVERFLOW;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			wp <= '0;
			rp <= '0;
			count <= '0;
		end
		else if (clear)
		begin
			wp <= '0;
			rp <= '0;
			count <= '0;
		end
		else
		begin
			if (do_wr)
				wp <= wp + 1'b1;
			if (do_rd)
				rp <= rp + 1'b1;
			if (do_wr && !do_rd)
				count <= count + 1'b1;
			else if (do_rd && !do_wr)
				count <= count - 1'b1;
		end
	end

	// empty queue answers with the no-error code
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			rd_data <= ser_pkg::SER_ERR_NONE;
		else if (rd_en)
			rd_data <= do_rd ? mem[rp] : ser_pkg::SER_ERR_NONE;
	end

endmodule

// *** src/ser_status.sv ***
// Purpose: event register, masks, status summary byte and error queue
// Assumes: a command parser delivers one-cycle command strobes and data
// Notes: message text is looked up from the returned code by the parser
`timescale 1ns/1ps
module ser_status
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic cmd_valid,
	input wire ser_pkg::ser_op_t cmd_op,
	input wire logic [7:0] cmd_data,
	input wire logic err_valid,
	input wire logic signed [15:0] err_code,
	input wire logic msg_put,
	input wire logic msg_taken,
	output logic resp_valid,
	output logic [15:0] resp_data,
	output logic service_request
);

	logic [7:0] event_reg;
	logic [7:0] event_enable_mask;
	logic [7:0] service_enable_mask;
	logic message_waiting_bit;
	logic event_summary_bit;
	logic master_summary_bit;
	logic [7:0] status_summary_byte;
	logic [7:0] err_bits;
	logic [15:0] err_mag;
	logic clr;
	logic rd_event;
	logic q_rd;
	logic q_full;
	logic q_empty;
	logic err_pend;
	logic signed [15:0] q_data;

	assign clr = cmd_valid && cmd_op == ser_pkg::SER_OP_CLEAR_STATUS;
	assign rd_event = cmd_valid && cmd_op == ser_pkg::SER_OP_EVENT_RD;
	assign q_rd = cmd_valid && cmd_op == ser_pkg::SER_OP_ERROR_RD;

	////////////////////////////////////////////////////////////////////
	// error group decode
	assign err_mag = 16'(-err_code);
	always_comb
	begin
		err_bits = 8'h00;
		if (err_valid)
		begin
			case (err_mag / ser_pkg::SER_GROUP_SPAN)
				16'h0001: err_bits[ser_pkg::SER_BIT_CMD_ERR] = 1'b1;
				16'h0002: err_bits[ser_pkg::SER_BIT_EXEC_ERR] = 1'b1;
				16'h0003: err_bits[ser_pkg::SER_BIT_DEVICE_ERR] = 1'b1;
				16'h0004: err_bits[ser_pkg::SER_BIT_QUERY_ERR] = 1'b1;
				default: err_bits = 8'h00;
			endcase
		end
	end

	// new events win over a same-cycle clear
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			event_reg <= ser_pkg::SER_EVENT_RESET;
		else if (clr || rd_event)
			event_reg <= err_bits;
		else
			event_reg <= event_reg | err_bits;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			event_enable_mask <= ser_pkg::SER_EVENT_MASK_RESET;
		else if (cmd_valid && cmd_op == ser_pkg::SER_OP_EVENT_MASK_WR)
			event_enable_mask <= cmd_data;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			service_enable_mask <= ser_pkg::SER_SERVICE_MASK_RESET;
		else if (cmd_valid && cmd_op == ser_pkg::SER_OP_SERVICE_MASK_WR)
			service_enable_mask <= cmd_data
				& ser_pkg::SER_SERVICE_MASK_USED;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			message_waiting_bit <= 1'b0;
		else if (msg_put)
			message_waiting_bit <= 1'b1;
		else if (clr || msg_taken)
			message_waiting_bit <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// summary bits stay unlatched so a read always sees live state
	assign event_summary_bit = |(event_reg & event_enable_mask);
	always_comb
	begin
		status_summary_byte = 8'h00;
		status_summary_byte[ser_pkg::SER_BIT_MSG_WAIT] = message_waiting_bit;
		status_summary_byte[ser_pkg::SER_BIT_EVT_SUM] = event_summary_bit;
		master_summary_bit = |(status_summary_byte & service_enable_mask);
		status_summary_byte[ser_pkg::SER_BIT_MASTER] = master_summary_bit;
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			service_request <= 1'b0;
		else
			service_request <= master_summary_bit;
	end

	////////////////////////////////////////////////////////////////////
	ser_err_queue u_queue
	(
		.clk(clk),
		.rstn(rstn),
		.clear(clr),
		.wr_en(err_valid),
		.wr_data(err_code),
		.rd_en(q_rd),
		.rd_data(q_data),
		.full(q_full),
		.empty(q_empty)
	);

	// register queries answer next cycle, the error query one later
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			resp_valid <= 1'b0;
			resp_data <= 16'h0000;
			err_pend <= 1'b0;
		end
		else
		begin
			err_pend <= q_rd;
			resp_valid <= 1'b0;
			if (err_pend)
			begin
				resp_valid <= 1'b1;
				resp_data <= q_data;
			end
			else if (cmd_valid)
			begin
				case (cmd_op)
					ser_pkg::SER_OP_EVENT_MASK_RD:
					begin
						resp_valid <= 1'b1;
						resp_data <= {8'h00, event_enable_mask};
					end
					ser_pkg::SER_OP_EVENT_RD:
					begin
						resp_valid <= 1'b1;
						resp_data <= {8'h00, event_reg};
					end
					ser_pkg::SER_OP_SUMMARY_RD:
					begin
						resp_valid <= 1'b1;
						resp_data <= {8'h00, status_summary_byte};
					end
					ser_pkg::SER_OP_SERVICE_MASK_RD:
					begin
						resp_valid <= 1'b1;
						resp_data <= {8'h00, service_enable_mask};
					end
					default: resp_valid <= 1'b0;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	sequence s_event_read;
		rd_event && !err_valid;
	endsequence

	// a summary query that the error answer does not push aside
	sequence s_summary_read;
		cmd_valid && cmd_op == ser_pkg::SER_OP_SUMMARY_RD && !err_pend;
	endsequence

	sequence s_empty_query;
		q_rd && q_empty;
	endsequence

	property p_event_clear;
		@(posedge clk) disable iff (!rstn)
		s_event_read |=> event_reg == 8'h00;
	endproperty
	a_event_clear: assert property (p_event_clear)
		else $error("event register not cleared by read");

	property p_event_read_value;
		@(posedge clk) disable iff (!rstn)
		rd_event && !err_pend |=> resp_valid && resp_data[7:0] == $past(event_reg);
	endproperty
	a_event_read_value: assert property (p_event_read_value)
		else $error("event read returned wrong value");

	property p_summary_stable;
		@(posedge clk) disable iff (!rstn)
		cmd_valid && cmd_op == ser_pkg::SER_OP_SUMMARY_RD && !err_valid
			&& !msg_put && !msg_taken |=> $stable(status_summary_byte);
	endproperty
	a_summary_stable: assert property (p_summary_stable)
		else $error("summary byte changed by its read");

	property p_no_request_zero_mask;
		@(posedge clk) disable iff (!rstn)
		service_enable_mask == 8'h00 |=> !service_request;
	endproperty
	a_no_request_zero_mask: assert property (p_no_request_zero_mask)
		else $error("service request with zero mask");

	property p_mask_unused;
		@(posedge clk) disable iff (!rstn)
		(service_enable_mask & ~ser_pkg::SER_SERVICE_MASK_USED) == 8'h00;
	endproperty
	a_mask_unused: assert property (p_mask_unused)
		else $error("unused service mask bit set");

	property p_summary_rule;
		@(posedge clk) disable iff (!rstn)
		s_summary_read |=> resp_valid && resp_data[ser_pkg::SER_BIT_EVT_SUM]
			== $past(|(event_reg & event_enable_mask));
	endproperty
	a_summary_rule: assert property (p_summary_rule)
		else $error("event summary bit mismatch");

	property p_master_read;
		@(posedge clk) disable iff (!rstn)
		s_summary_read |=> resp_data[ser_pkg::SER_BIT_MASTER] == $past(
			message_waiting_bit && service_enable_mask[ser_pkg::SER_BIT_MSG_WAIT]
			|| event_summary_bit && service_enable_mask[ser_pkg::SER_BIT_EVT_SUM]);
	endproperty
	a_master_read: assert property (p_master_read)
		else $error("master summary bit mismatch");

	property p_cmd_error_group;
		@(posedge clk) disable iff (!rstn)
		err_valid && err_code == ser_pkg::SER_ERR_SYNTAX
			|=> event_reg[ser_pkg::SER_BIT_CMD_ERR];
	endproperty
	a_cmd_error_group: assert property (p_cmd_error_group)
		else $error("command error bit not set");

	property p_clear_wait;
		@(posedge clk) disable iff (!rstn)
		clr && !msg_put |=> !message_waiting_bit
			&& status_summary_byte[ser_pkg::SER_BIT_MSG_WAIT] == 1'b0;
	endproperty
	a_clear_wait: assert property (p_clear_wait)
		else $error("message waiting not cleared");

	property p_error_answer;
		@(posedge clk) disable iff (!rstn)
		s_empty_query |=> ##1 resp_valid && resp_data == 16'h0000;
	endproperty
	a_error_answer: assert property (p_error_answer)
		else $error("empty error query wrong answer");

	property p_overflow_drop;
		@(posedge clk) disable iff (!rstn)
		err_valid && q_full && !q_rd && !clr |=> q_full;
	endproperty
	a_overflow_drop: assert property (p_overflow_drop)
		else $error("full error queue did not stay full");

	property p_event_mask_write;
		@(posedge clk) disable iff (!rstn)
		cmd_valid && cmd_op == ser_pkg::SER_OP_EVENT_MASK_WR
			|=> event_enable_mask == $past(cmd_data);
	endproperty
	a_event_mask_write: assert property (p_event_mask_write)
		else $error("event mask write not taken");

	property p_mask_write;
		@(posedge clk) disable iff (!rstn)
		cmd_valid && cmd_op == ser_pkg::SER_OP_SERVICE_MASK_WR
			&& cmd_data[ser_pkg::SER_BIT_MSG_WAIT] && message_waiting_bit
			##1 message_waiting_bit |=> service_request;
	endproperty
	a_mask_write: assert property (p_mask_write)
		else $error("service request late after mask write");

endmodule

// *** dv/ser_host.sv ***
// Purpose: remote host model that issues parsed commands and queries
// Assumes: the host waits for each answer before the next request
// Notes: idle command lines toggle so stale values are never trusted
`timescale 1ns/1ps
module ser_host
(
	input wire logic clk,
	input wire logic resp_valid,
	input wire logic [15:0] resp_data,
	output ser_pkg::ser_op_t cmd_op,
	output logic cmd_valid,
	output logic [7:0] cmd_data
);
	initial
	begin
		cmd_valid = 1'b0;
		cmd_op = ser_pkg::SER_OP_NONE;
		cmd_data = 8'h00;
	end
	////////////////////////////////////////////////////////////////////////
	task send(input ser_pkg::ser_op_t op, input logic [7:0] dat);
	begin
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_op = op;
		cmd_data = dat;
		@(negedge clk);
		cmd_valid = 1'b0;
		cmd_op = ser_pkg::ser_op_t'(~op);
		cmd_data = ~dat;
	end
	endtask
	// waiting for the answer keeps queries out of the slot after an error read
	task query(input ser_pkg::ser_op_t op, output logic [15:0] dat);
		int n;
	begin
		send(op, 8'h00);
		n = 0;
		while (resp_valid !== 1'b1 && n < 4)
		begin
			@(negedge clk);
			n++;
		end
		dat = (resp_valid === 1'b1) ? resp_data : 16'hXXXX;
	end
	endtask
endmodule

// *** dv/ser_status_tb.sv ***
// Purpose: self-checking bench for the status event reporting block
// Assumes: inputs change on the falling clock edge
// Notes: queue depth comes from the package, no long counts needed
`timescale 1ns/1ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_fail++; \
	$display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module ser_status_tb;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic err_valid = 1'b0;
	logic signed [15:0] err_code = 16'h0000;
	logic msg_put = 1'b0;
	logic msg_taken = 1'b0;
	logic cmd_valid, resp_valid, service_request;
	ser_pkg::ser_op_t cmd_op;
	logic [7:0] cmd_data;
	logic [15:0] resp_data, d, e;
	int n_fail = 0;
	int checks = 0;
	int cyc = 0;
	logic signed [15:0] codes [6] = '{ser_pkg::SER_ERR_CMD,
		ser_pkg::SER_ERR_SYNTAX, ser_pkg::SER_ERR_PARAM,
		ser_pkg::SER_ERR_RANGE, ser_pkg::SER_ERR_OVERFLOW,
		ser_pkg::SER_ERR_QUERY};
	logic [15:0] bits [6] = '{16'h0020, 16'h0020, 16'h0020, 16'h0010,
		16'h0008, 16'h0004};
	always #12.5 clk = ~clk;
	////////////////////////////////////////////////////////////////////////
	ser_status i_ser_status (.clk(clk), .rstn(rstn), .cmd_valid(cmd_valid),
		.cmd_op(cmd_op), .cmd_data(cmd_data), .err_valid(err_valid),
		.err_code(err_code), .msg_put(msg_put), .msg_taken(msg_taken),
		.resp_valid(resp_valid), .resp_data(resp_data),
		.service_request(service_request));
	ser_host i_ser_host (.clk(clk), .resp_valid(resp_valid),
		.resp_data(resp_data), .cmd_op(cmd_op), .cmd_valid(cmd_valid),
		.cmd_data(cmd_data));
	////////////////////////////////////////////////////////////////////////
	task give_verdict();
	begin
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask
	task rd(input ser_pkg::ser_op_t op, input logic [15:0] exp_v);
	begin
		i_ser_host.query(op, d);
		`CHK(d, exp_v)
	end
	endtask
	task wr(input ser_pkg::ser_op_t op, input logic [7:0] v);
	begin
		i_ser_host.send(op, v);
	end
	endtask
	task err(input logic signed [15:0] code);
	begin
		@(negedge clk);
		err_valid = 1'b1;
		err_code = code;
		@(negedge clk);
		err_valid = 1'b0;
		err_code = ~code;
	end
	endtask
	// the mask write and the service request each go through a register, so allow two edges
	task srq(input logic exp_v);
	begin
		repeat (2) @(negedge clk);
		`CHK(service_request, exp_v)
	end
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_fail++;
			give_verdict();
		end
	end
	initial
	begin
		repeat (10) @(negedge clk);
		rstn = 1'b1;
		rd(ser_pkg::SER_OP_EVENT_RD, 16'h0080);
		rd(ser_pkg::SER_OP_EVENT_RD, 16'h0000);
		rd(ser_pkg::SER_OP_SUMMARY_RD, 16'h0000);
		wr(ser_pkg::SER_OP_EVENT_MASK_WR, 8'hA5);
		rd(ser_pkg::SER_OP_EVENT_MASK_RD, 16'h00A5);
		err(ser_pkg::SER_ERR_RANGE);
		rd(ser_pkg::SER_OP_SUMMARY_RD, 16'h0000);
		wr(ser_pkg::SER_OP_EVENT_MASK_WR, 8'h10);
		rd(ser_pkg::SER_OP_SUMMARY_RD, 16'h0020);
		rd(ser_pkg::SER_OP_SUMMARY_RD, 16'h0020);
		wr(ser_pkg::SER_OP_SERVICE_MASK_WR, 8'hFF);
		srq(1'b1);
		rd(ser_pkg::SER_OP_SERVICE_MASK_RD, 16'h0030);
		rd(ser_pkg::SER_OP_SUMMARY_RD, 16'h0060);
		wr(ser_pkg::SER_OP_SERVICE_MASK_WR, 8'h00);
		srq(1'b0);
		rd(ser_pkg::SER_OP_SUMMARY_RD, 16'h0020);
		@(negedge clk);
		msg_put = 1'b1;
		@(negedge clk);
		msg_put = 1'b0;
		rd(ser_pkg::SER_OP_SUMMARY_RD, 16'h0030);
		msg_taken = 1'b1;
		@(negedge clk);
		msg_taken = 1'b0;
		rd(ser_pkg::SER_OP_SUMMARY_RD, 16'h0020);
		msg_put = 1'b1;
		@(negedge clk);
		msg_put = 1'b0;
		// message waiting alone must raise the request
		wr(ser_pkg::SER_OP_SERVICE_MASK_WR, 8'h10);
		srq(1'b1);
		rd(ser_pkg::SER_OP_SERVICE_MASK_RD, 16'h0010);
		wr(ser_pkg::SER_OP_CLEAR_STATUS, 8'h00);
		srq(1'b0);
		rd(ser_pkg::SER_OP_SUMMARY_RD, 16'h0000);
		rd(ser_pkg::SER_OP_EVENT_RD, 16'h0000);
		rd(ser_pkg::SER_OP_ERROR_RD, 16'h0000);
		foreach (codes[i])
		begin
			err(codes[i]);
			rd(ser_pkg::SER_OP_EVENT_RD, bits[i]);
		end
		foreach (codes[i])
			rd(ser_pkg::SER_OP_ERROR_RD, codes[i]);
		rd(ser_pkg::SER_OP_ERROR_RD, 16'h0000);
		// one more error than the queue holds
		for (int k = 0; k <= ser_pkg::SER_QUEUE_DEPTH; k++)
			err(ser_pkg::SER_ERR_CMD - 16'(k));
		for (int k = 0; k <= ser_pkg::SER_QUEUE_DEPTH; k++)
		begin
			e = ser_pkg::SER_ERR_CMD - 16'(k);
			if (k == ser_pkg::SER_QUEUE_DEPTH - 1)
				e = ser_pkg::SER_ERR_OVERFLOW;
			if (k == ser_pkg::SER_QUEUE_DEPTH)
				e = 16'h0000;
			rd(ser_pkg::SER_OP_ERROR_RD, e);
		end
		// a second reset in mid-run must bring back the power-on state
		@(negedge clk);
		rstn = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		rd(ser_pkg::SER_OP_EVENT_RD, 16'h0080);
		rd(ser_pkg::SER_OP_SERVICE_MASK_RD, 16'h0000);
		rd(ser_pkg::SER_OP_SUMMARY_RD, 16'h0000);
		give_verdict();
	end
endmodule
